/* File: tsdb_defs.svh */
`ifndef TSDB_DEFS_SVH
`define TSDB_DEFS_SVH

// ****************************************
// register word offsets (avalon word address)
// ****************************************
`define TSDB_OFF_SENSE0 3'h0
`define TSDB_OFF_SENSE3 3'h3
`define TSDB_OFF_CTRL 3'h4
`define TSDB_OFF_STAT 3'h5

// ****************************************
// control register fields
// ****************************************
`define TSDB_CTRL_CLR_BIT 0
`define TSDB_CTRL_CART_BIT 1

// ****************************************
// sense record layout
// ****************************************
`define TSDB_B0_LOW7 7'h70
`define TSDB_B1_VAL 8'h00
`define TSDB_ADD_LEN 8'h08
`define TSDB_REC_LAST 4'hf
`define TSDB_DEF_ALLOC 8'h04

// ****************************************
// sense keys
// ****************************************
`define TSDB_KEY_NONE 4'h0
`define TSDB_KEY_RECOV 4'h1
`define TSDB_KEY_NREADY 4'h2
`define TSDB_KEY_MEDIA 4'h3
`define TSDB_KEY_HW 4'h4
`define TSDB_KEY_ILLEGAL 4'h5
`define TSDB_KEY_UATTN 4'h6
`define TSDB_KEY_PROTECT 4'h7
`define TSDB_KEY_BLANK 4'h8
`define TSDB_KEY_OVFL 4'hd

// ****************************************
// reset values, limits, bus answers
// ****************************************
`define TSDB_UA_RST 8'hff
`define TSDB_POR_RST 1'b1
`define TSDB_RETRY_LIMIT 5'h10
`define TSDB_RESP_OK 2'h0
`define TSDB_RESP_SLVERR 2'h2

`endif

/* File: tsdb_pkg.sv */
package tsdb_pkg;

    // ****************************************
    // sense transfer states
    // ****************************************
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SEND = 3'b010,
        ST_DONE = 3'b100
    } tsdb_state_e;

    // ****************************************
    // status returned for a command
    // ****************************************
    typedef enum logic [1:0]
    {
        STAT_GOOD = 2'h0,
        STAT_CHECK = 2'h1,
        STAT_BUSY = 2'h2
    } tsdb_status_e;

endpackage

/* File: tsdb_sense_builder.sv */
`timescale 1ns/100ps
`include "tsdb_defs.svh"

module tsdb_sense_builder
(
    // clock, reset, enable
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic CLK_EN_I,
    // avalon-mm slave
    input wire logic [2:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    output logic [1:0] AVS_RESPONSE_O,
    // command arrival and answer
    input wire logic CMD_VALID_I,
    input wire logic [2:0] CMD_HOST_I,
    input wire logic CMD_SENSE_I,
    input wire logic [7:0] CMD_ALLOC_I,
    output logic CMD_DONE_O,
    output tsdb_pkg::tsdb_status_e CMD_STATUS_O,
    output logic CMD_EXEC_O,
    // sense byte stream
    output logic SENSE_VALID_O,
    output logic [7:0] SENSE_DATA_O,
    output logic SENSE_LAST_O,
    input wire logic SENSE_READY_I,
    // drive and controller events
    input wire logic BUS_RESET_I,
    input wire logic CART_CHANGE_I,
    input wire logic FILEMARK_I,
    input wire logic EOM_WARN_I,
    input wire logic LAST_TRACK_I,
    input wire logic NO_CART_I,
    input wire logic WRPROT_I,
    input wire logic BLOCK_FAIL_I,
    input wire logic BLOCK_MISS_I,
    input wire logic BLOCK_OK_I,
    input wire logic ERASED_I,
    input wire logic AT_BOM_I,
    input wire logic PARITY_ERR_I,
    input wire logic RETRY_I,
    input wire logic UNDERRUN_I,
    input wire logic [7:0] TRACK_I,
    input wire logic [7:0] BLOCKS_TO_GO_I,
    input wire logic RESID_LOAD_I,
    input wire logic [31:0] RESID_COUNT_I,
    // check sources
    input wire logic CHECK_REQ_I,
    input wire logic [3:0] CHECK_KEY_I,
    input wire logic ILLEGAL_DATA_I,
    input wire logic ILLEGAL_CDB_I,
    input wire logic CDB_DONE_I,
    input wire logic BLANK_I,
    input wire logic VOL_OVFL_I,
    input wire logic WRITE_TRY_I,
    // check and reset results
    output logic CHECK_O,
    output logic CLR_RESERVE_O
);
    import tsdb_pkg::*;

    // ****************************************
    // byte pick from the 16-byte record
    // ****************************************
    function automatic logic [7:0] rec_byte(input logic [127:0] rec, input logic [7:0] idx);
        logic [3:0] pos;
        pos = `TSDB_REC_LAST - idx[3:0];
        rec_byte = (idx[7:4] != 4'h0) ? 8'h00 : rec[{pos, 3'b000} +: 8];
    endfunction

    // ****************************************
    // state
    // ****************************************
    tsdb_state_e st_r, st_nxt;
    logic pend_r, pend_nxt;
    logic [2:0] owner_r, owner_nxt;
    logic [2:0] cur_host_r;
    logic [7:0] ua_r, ua_nxt;
    logic [3:0] key_r, key_nxt;
    logic valid_r, fm_r, eom_r, unr_r, bnf_r, erase_r, par_r, por_r;
    logic nocart_r, wp_r, bom_r;
    logic [31:0] resid_r;
    logic [15:0] retry_r, urun_r;
    logic [7:0] track_r, btg_r;
    logic [4:0] fail_cnt_r, miss_cnt_r;
    logic cdb_bad_r;
    logic [7:0] idx_r, len_r;
    logic sense_own_r;
    logic wait_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;
    logic done_r, exec_r, sval_r, slast_r, chk_r, clrres_r;
    tsdb_status_e stat_r;
    logic [7:0] sdata_r;

    // ****************************************
    // command decode
    // ****************************************
    wire logic cmd_take_w = CMD_VALID_I & (st_r == ST_IDLE);
    wire logic busy_w = pend_r & (CMD_HOST_I != owner_r);
    wire logic ua_hit_w = ua_r[CMD_HOST_I] & ~busy_w;
    wire logic ua_chk_w = cmd_take_w & ua_hit_w & ~CMD_SENSE_I;
    wire logic sense_go_w = cmd_take_w & ~busy_w & CMD_SENSE_I;
    wire logic exec_go_w = cmd_take_w & ~busy_w & ~ua_hit_w & ~CMD_SENSE_I;
    wire logic [7:0] ua_bit_w = 8'h01 << CMD_HOST_I;

    // ****************************************
    // avalon decode
    // ****************************************
    wire logic acc_w = AVS_READ_I | AVS_WRITE_I;
    wire logic commit_w = AVS_WRITE_I & ~wait_r;
    wire logic ctrl_wr_w = commit_w & (AVS_ADDRESS_I == `TSDB_OFF_CTRL) & AVS_BYTEENABLE_I[0];
    wire logic sw_clr_w = ctrl_wr_w & AVS_WRITEDATA_I[`TSDB_CTRL_CLR_BIT];
    wire logic sw_cart_w = ctrl_wr_w & AVS_WRITEDATA_I[`TSDB_CTRL_CART_BIT];
    wire logic sense_sel_w = AVS_ADDRESS_I <= `TSDB_OFF_SENSE3;
    wire logic mapped_w = sense_sel_w | (AVS_ADDRESS_I == `TSDB_OFF_CTRL) | (AVS_ADDRESS_I == `TSDB_OFF_STAT);

    // ****************************************
    // record clear and check sources
    // ****************************************
    wire logic own_done_w = (st_r == ST_DONE) & sense_own_r;
    wire logic clr_w = sw_clr_w | own_done_w | (exec_go_w & pend_r);
    wire logic unr_ev_w = BLOCK_FAIL_I & (fail_cnt_r == (`TSDB_RETRY_LIMIT - 5'h01));
    wire logic bnf_ev_w = BLOCK_MISS_I & (miss_cnt_r == (`TSDB_RETRY_LIMIT - 5'h01));
    wire logic prot_ev_w = WRITE_TRY_I & wp_r;
    // bad data at once, bad cdb at end
    wire logic ill_ev_w = ILLEGAL_DATA_I | (CDB_DONE_I & (cdb_bad_r | ILLEGAL_CDB_I));
    wire logic int_chk_w = CHECK_REQ_I | unr_ev_w | bnf_ev_w | prot_ev_w | ill_ev_w | BLANK_I | VOL_OVFL_I;
    wire logic [3:0] int_key_w =
        ill_ev_w ? `TSDB_KEY_ILLEGAL :
        prot_ev_w ? `TSDB_KEY_PROTECT :
        (unr_ev_w | bnf_ev_w) ? `TSDB_KEY_MEDIA :
        BLANK_I ? `TSDB_KEY_BLANK :
        VOL_OVFL_I ? `TSDB_KEY_OVFL : CHECK_KEY_I;
    wire logic chk_set_w = ua_chk_w | int_chk_w;

    // ****************************************
    // record next values, set wins over clear
    // ****************************************
    assign pend_nxt = chk_set_w | (pend_r & ~clr_w);
    assign owner_nxt = ua_chk_w ? CMD_HOST_I : int_chk_w ? cur_host_r : owner_r;
    assign key_nxt = (BUS_RESET_I | ua_chk_w) ? `TSDB_KEY_UATTN :
                     int_chk_w ? int_key_w :
                     clr_w ? `TSDB_KEY_NONE : key_r;
    assign ua_nxt = (BUS_RESET_I | CART_CHANGE_I | sw_cart_w) ? `TSDB_UA_RST :
                    (cmd_take_w & ua_hit_w) ? (ua_r & ~ua_bit_w) : ua_r;

    // ****************************************
    // record image
    // ****************************************
    wire logic [127:0] rec_w =
    {
        valid_r, `TSDB_B0_LOW7,
        `TSDB_B1_VAL,
        fm_r, eom_r, 2'b00, key_r,
        resid_r,
        `TSDB_ADD_LEN,
        1'b0, nocart_r, 1'b0, wp_r, eom_r, unr_r, bnf_r, fm_r,
        2'b00, erase_r, 1'b0, bom_r, par_r, 1'b0, por_r,
        retry_r, urun_r,
        track_r, btg_r
    };

    // ****************************************
    // register read mux
    // ****************************************
    wire logic [31:0] sense_word_w;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_lane
            assign sense_word_w[8*g +: 8] = rec_byte(rec_w, {4'h0, AVS_ADDRESS_I[1:0], 2'(g)});
        end
    endgenerate
    wire logic [31:0] stat_word_w = {16'h0000, ua_r, 3'b000, (st_r != ST_IDLE), owner_r, pend_r};
    wire logic [31:0] rd_w = sense_sel_w ? sense_word_w :
                             (AVS_ADDRESS_I == `TSDB_OFF_STAT) ? stat_word_w : 32'h0000_0000;

    // ****************************************
    // sense stream next state
    // ****************************************
    wire logic step_w = sval_r & SENSE_READY_I;
    wire logic [7:0] len_w = (CMD_ALLOC_I == 8'h00) ? `TSDB_DEF_ALLOC : CMD_ALLOC_I;
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE:
            begin
                if (sense_go_w)
                begin
                    st_nxt = ST_SEND;
                end
            end
            ST_SEND:
            begin
                if (step_w & slast_r)
                begin
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE:
            begin
                st_nxt = ST_IDLE;
            end
            default:
            begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // avalon slave
    // ****************************************
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            wait_r <= 1'b1;
            rdata_r <= 32'h0000_0000;
            resp_r <= `TSDB_RESP_OK;
        end
        else if (CLK_EN_I)
        begin
            wait_r <= ~(acc_w & wait_r);
            if (acc_w & wait_r)
            begin
                rdata_r <= AVS_READ_I ? rd_w : 32'h0000_0000;
                resp_r <= mapped_w ? `TSDB_RESP_OK : `TSDB_RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // record control
    // ****************************************
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            pend_r <= 1'b0;
            owner_r <= 3'h0;
            cur_host_r <= 3'h0;
            ua_r <= `TSDB_UA_RST;
            key_r <= `TSDB_KEY_UATTN;
            cdb_bad_r <= 1'b0;
        end
        else if (CLK_EN_I)
        begin
            pend_r <= pend_nxt;
            owner_r <= owner_nxt;
            cur_host_r <= cmd_take_w ? CMD_HOST_I : cur_host_r;
            ua_r <= ua_nxt;
            key_r <= key_nxt;
            cdb_bad_r <= (cdb_bad_r | ILLEGAL_CDB_I) & ~CDB_DONE_I;
        end
    end

    // ****************************************
    // sticky flags
    // ****************************************
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            {valid_r, fm_r, eom_r, unr_r, bnf_r, erase_r, par_r} <= 7'h00;
            por_r <= `TSDB_POR_RST;
            resid_r <= 32'h0000_0000;
        end
        else if (CLK_EN_I)
        begin
            valid_r <= RESID_LOAD_I | (valid_r & ~clr_w);
            resid_r <= RESID_LOAD_I ? RESID_COUNT_I : (clr_w ? 32'h0000_0000 : resid_r);
            fm_r <= FILEMARK_I | (fm_r & ~clr_w);
            eom_r <= (EOM_WARN_I & LAST_TRACK_I) | (eom_r & ~clr_w);
            unr_r <= unr_ev_w | (unr_r & ~clr_w);
            bnf_r <= bnf_ev_w | (bnf_r & ~clr_w);
            erase_r <= ERASED_I | (erase_r & ~clr_w);
            par_r <= PARITY_ERR_I | (par_r & ~clr_w);
            por_r <= BUS_RESET_I | (por_r & ~clr_w);
        end
    end

    // ****************************************
    // counters and live drive state
    // ****************************************
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            retry_r <= 16'h0000;
            urun_r <= 16'h0000;
            fail_cnt_r <= 5'h00;
            miss_cnt_r <= 5'h00;
            {nocart_r, wp_r, bom_r} <= 3'b000;
            track_r <= 8'h00;
            btg_r <= 8'h00;
        end
        else if (CLK_EN_I)
        begin
            retry_r <= (RETRY_I & (retry_r != 16'hffff)) ? retry_r + 16'h0001 : (clr_w ? 16'h0000 : retry_r);
            urun_r <= (UNDERRUN_I & (urun_r != 16'hffff)) ? urun_r + 16'h0001 : (clr_w ? 16'h0000 : urun_r);
            fail_cnt_r <= (BLOCK_OK_I | unr_ev_w) ? 5'h00 : fail_cnt_r + {4'h0, BLOCK_FAIL_I};
            miss_cnt_r <= (BLOCK_OK_I | bnf_ev_w) ? 5'h00 : miss_cnt_r + {4'h0, BLOCK_MISS_I};
            {nocart_r, wp_r, bom_r} <= {NO_CART_I, WRPROT_I, AT_BOM_I};
            track_r <= TRACK_I;
            btg_r <= BLOCKS_TO_GO_I;
        end
    end

    // ****************************************
    // sense stream and command answers
    // ****************************************
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I || (CLK_EN_I && BUS_RESET_I))
        begin
            st_r <= ST_IDLE;
            {idx_r, len_r} <= 16'h0000;
            {sval_r, slast_r, sense_own_r} <= 3'b000;
            sdata_r <= 8'h00;
        end
        else if (CLK_EN_I)
        begin
            st_r <= st_nxt;
            if (sense_go_w)
            begin
                idx_r <= 8'h00;
                len_r <= len_w;
                sval_r <= 1'b1;
                sdata_r <= rec_byte(rec_w, 8'h00);
                slast_r <= (len_w == 8'h01);
                sense_own_r <= pend_r & (owner_r == CMD_HOST_I);
            end
            else if (step_w)
            begin
                idx_r <= idx_r + 8'h01;
                sval_r <= ~slast_r;
                sdata_r <= rec_byte(rec_w, idx_r + 8'h01);
                slast_r <= (idx_r + 8'h02 == len_r);
            end
        end
    end

    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            {done_r, exec_r, chk_r, clrres_r} <= 4'h0;
            stat_r <= STAT_GOOD;
        end
        else if (CLK_EN_I)
        begin
            done_r <= (cmd_take_w & (busy_w | ua_hit_w) & ~CMD_SENSE_I) | (st_r == ST_DONE);
            stat_r <= (cmd_take_w & busy_w) ? STAT_BUSY : ua_chk_w ? STAT_CHECK :
                      (st_r == ST_DONE) ? STAT_GOOD : stat_r;
            exec_r <= exec_go_w;
            chk_r <= int_chk_w;
            clrres_r <= BUS_RESET_I;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign AVS_READDATA_O = rdata_r;
    assign AVS_WAITREQUEST_O = wait_r;
    assign AVS_RESPONSE_O = resp_r;
    assign CMD_DONE_O = done_r;
    assign CMD_STATUS_O = stat_r;
    assign CMD_EXEC_O = exec_r;
    assign SENSE_VALID_O = sval_r;
    assign SENSE_DATA_O = sdata_r;
    assign SENSE_LAST_O = slast_r;
    assign CHECK_O = chk_r;
    assign CLR_RESERVE_O = clrres_r;

endmodule

/* File: tsdb_checker.sv */
`timescale 1ns/100ps
`include "tsdb_defs.svh"
module tsdb_checker
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // bus
    input wire logic [2:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic AVS_WAITREQUEST_O,
    input wire logic [1:0] AVS_RESPONSE_O,
    // command and stream
    input wire logic CMD_VALID_I,
    input wire logic CMD_SENSE_I,
    input wire logic [7:0] CMD_ALLOC_I,
    input wire logic CMD_DONE_O,
    input wire tsdb_pkg::tsdb_status_e CMD_STATUS_O,
    input wire logic SENSE_VALID_O,
    input wire logic [7:0] SENSE_DATA_O,
    input wire logic SENSE_LAST_O,
    input wire logic SENSE_READY_I,
    // events and results
    input wire logic BUS_RESET_I,
    input wire logic ILLEGAL_DATA_I,
    input wire logic CHECK_O,
    input wire logic CLR_RESERVE_O
);
    import tsdb_pkg::*;
    // ****************************************
    // stream position tracking
    // ****************************************
    logic [7:0] idx_r;
    logic [7:0] idx_nxt;
    logic [7:0] last_r;
    logic fm_r;
    logic eom_r;
    wire take = SENSE_VALID_O && SENSE_READY_I;
    wire sense_req = CMD_VALID_I && CMD_SENSE_I && !SENSE_VALID_O;
    assign idx_nxt = idx_r + 8'h01;
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I || !SENSE_VALID_O)
            idx_r <= 8'h00;
        else if (SENSE_READY_I)
            idx_r <= idx_nxt;
    end
    always_ff @(posedge SYS_CLK_I)
    begin
        if (sense_req)
            last_r <= (CMD_ALLOC_I == 8'h00) ? 8'h03 : CMD_ALLOC_I - 8'h01;
        if (take && idx_r == 8'h02)
        begin
            fm_r <= SENSE_DATA_O[7];
            eom_r <= SENSE_DATA_O[6];
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    sequence s_last_taken;
        take && SENSE_LAST_O;
    endsequence
    sequence s_good_end;
        !SENSE_VALID_O ##1 (CMD_DONE_O && CMD_STATUS_O == STAT_GOOD);
    endsequence
    bus_answer_a:
        assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("bus answer late");
    bus_unmapped_a:
        assert property (AVS_READ_I && AVS_WAITREQUEST_O && AVS_ADDRESS_I > 3'h5 |=> AVS_RESPONSE_O == `TSDB_RESP_SLVERR)
        else $error("unmapped read not refused");
    fmt_byte0_a:
        assert property (SENSE_VALID_O && idx_r == 8'h00 |-> SENSE_DATA_O[6:0] == `TSDB_B0_LOW7) else $error("byte 0 format");
    zero_byte1_a:
        assert property (SENSE_VALID_O && idx_r == 8'h01 |-> SENSE_DATA_O == 8'h00) else $error("byte 1 not zero");
    key_pad_a:
        assert property (SENSE_VALID_O && idx_r == 8'h02 |-> SENSE_DATA_O[5:4] == 2'h0) else $error("byte 2 pad bits");
    add_len_a:
        assert property (SENSE_VALID_O && idx_r == 8'h07 |-> SENSE_DATA_O == 8'h08) else $error("additional length");
    mark_mirror_a:
        assert property (SENSE_VALID_O && idx_r == 8'h08 |-> SENSE_DATA_O[0] == fm_r && SENSE_DATA_O[3] == eom_r)
        else $error("byte 8 mirror bits differ");
    alloc_len_a:
        assert property (SENSE_VALID_O |-> SENSE_LAST_O == (idx_r == last_r)) else $error("stream length");
    sense_hold_a:
        assert property (SENSE_VALID_O && !SENSE_READY_I && !BUS_RESET_I |=> SENSE_VALID_O && $stable(SENSE_DATA_O))
        else $error("byte dropped");
    sense_end_a:
        assert property (s_last_taken |=> s_good_end) else $error("sense end status");
    reserve_clear_a:
        assert property (BUS_RESET_I |=> CLR_RESERVE_O) else $error("reservations not cleared");
    bad_data_a:
        assert property (ILLEGAL_DATA_I |=> CHECK_O) else $error("check late on bad data");
endmodule
bind tsdb_sense_builder tsdb_checker i_tsdb_checker (.SYS_CLK_I, .RST_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
    .AVS_WAITREQUEST_O, .AVS_RESPONSE_O, .CMD_VALID_I, .CMD_SENSE_I, .CMD_ALLOC_I, .CMD_DONE_O, .CMD_STATUS_O,
    .SENSE_VALID_O, .SENSE_DATA_O, .SENSE_LAST_O, .SENSE_READY_I, .BUS_RESET_I, .ILLEGAL_DATA_I, .CHECK_O,
    .CLR_RESERVE_O);

/* File: tsdb_host_model.sv */
`timescale 1ns/100ps
module tsdb_host_model
(
    // clock and pacing
    input wire logic clk_i,
    input wire logic slow_i,
    // command side
    output logic cmd_valid_o,
    output logic [2:0] cmd_host_o,
    output logic cmd_sense_o,
    output logic [7:0] cmd_alloc_o,
    input wire logic cmd_done_i,
    input wire tsdb_pkg::tsdb_status_e cmd_status_i,
    input wire logic cmd_exec_i,
    // sense stream
    input wire logic sense_valid_i,
    input wire logic [7:0] sense_data_i,
    output logic sense_ready_o
);
    import tsdb_pkg::*;
    logic [7:0] rx [0:31];
    logic [2:0] res;
    int n = 0;
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_host_o = 3'h0;
        cmd_sense_o = 1'b0;
        cmd_alloc_o = 8'h00;
        sense_ready_o = 1'b1;
    end
    // slow mode drops ready every other cycle
    always @(posedge clk_i)
    begin
        sense_ready_o <= slow_i ? ~sense_ready_o : 1'b1;
        if (sense_valid_i && sense_ready_o)
        begin
            rx[n[4:0]] <= sense_data_i;
            n <= n + 1;
        end
    end
    task cmd(input [2:0] h, input s, input [7:0] a);
        int k;
        n = 0;
        res = 3'h7;
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_host_o <= h;
        cmd_sense_o <= s;
        cmd_alloc_o <= a;
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_host_o <= ~h;
        cmd_alloc_o <= ~a;
        for (k = 0; k < 300 && res == 3'h7; k++)
        begin
            @(posedge clk_i);
            if (cmd_done_i || cmd_exec_i)
                res = cmd_exec_i ? 3'h4 : {1'b0, cmd_status_i};
        end
    endtask
endmodule

/* File: tb_tsdb_sense_builder.sv */
`timescale 1ns/100ps
`include "tsdb_defs.svh"
module tb_tsdb_sense_builder;
    import tsdb_pkg::*;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic SYS_CLK_I = 0, RST_N_I = 0, CLK_EN_I = 1, slow = 0;
    logic [2:0] AVS_ADDRESS_I = 0, CMD_HOST_I;
    logic AVS_READ_I = 0, AVS_WRITE_I = 0, CMD_VALID_I, CMD_SENSE_I, SENSE_READY_I;
    logic [31:0] AVS_WRITEDATA_I = 0, RESID_COUNT_I = 0, AVS_READDATA_O, q;
    logic [3:0] AVS_BYTEENABLE_I = 4'hf, CHECK_KEY_I = 0;
    logic LAST_TRACK_I = 0, NO_CART_I = 0, WRPROT_I = 0, AT_BOM_I = 0;
    logic [7:0] TRACK_I = 8'h03, BLOCKS_TO_GO_I = 8'h05, CMD_ALLOC_I, SENSE_DATA_O;
    logic [18:0] ev = 0;
    logic AVS_WAITREQUEST_O, CMD_DONE_O, CMD_EXEC_O, SENSE_VALID_O, SENSE_LAST_O, CHECK_O, CLR_RESERVE_O;
    logic [1:0] AVS_RESPONSE_O, r;
    tsdb_status_e CMD_STATUS_O;
    wire BUS_RESET_I = ev[0], CART_CHANGE_I = ev[1], FILEMARK_I = ev[2], EOM_WARN_I = ev[3], BLOCK_FAIL_I = ev[4];
    wire BLOCK_MISS_I = ev[5], BLOCK_OK_I = ev[6], ERASED_I = ev[7], PARITY_ERR_I = ev[8], RETRY_I = ev[9];
    wire UNDERRUN_I = ev[10], RESID_LOAD_I = ev[11], CHECK_REQ_I = ev[12], ILLEGAL_DATA_I = ev[13];
    wire ILLEGAL_CDB_I = ev[14], CDB_DONE_I = ev[15], BLANK_I = ev[16], VOL_OVFL_I = ev[17], WRITE_TRY_I = ev[18];
    logic [7:0] exp3 [0:15] = '{8'hf0, 8'h00, 8'hc3, 8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h4f, 8'h2c, 8'h00, 8'h03,
        8'h00, 8'h02, 8'h03, 8'h05};
    logic [3:0] kkey [0:7] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h5, 4'h8, 4'hd, 4'h7};
    int kbit [0:7] = '{12, 12, 12, 13, 14, 16, 17, 18};
    int mismatches = 0, checks = 0, i;
    always #2 SYS_CLK_I = ~SYS_CLK_I;
    tsdb_sense_builder i_tsdb_sense_builder (.SYS_CLK_I, .RST_N_I, .CLK_EN_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
        .AVS_WRITEDATA_I, .AVS_BYTEENABLE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .AVS_RESPONSE_O, .CMD_VALID_I,
        .CMD_HOST_I, .CMD_SENSE_I, .CMD_ALLOC_I, .CMD_DONE_O, .CMD_STATUS_O, .CMD_EXEC_O, .SENSE_VALID_O,
        .SENSE_DATA_O, .SENSE_LAST_O, .SENSE_READY_I, .BUS_RESET_I, .CART_CHANGE_I, .FILEMARK_I, .EOM_WARN_I,
        .LAST_TRACK_I, .NO_CART_I, .WRPROT_I, .BLOCK_FAIL_I, .BLOCK_MISS_I, .BLOCK_OK_I, .ERASED_I, .AT_BOM_I,
        .PARITY_ERR_I, .RETRY_I, .UNDERRUN_I, .TRACK_I, .BLOCKS_TO_GO_I, .RESID_LOAD_I, .RESID_COUNT_I,
        .CHECK_REQ_I, .CHECK_KEY_I, .ILLEGAL_DATA_I, .ILLEGAL_CDB_I, .CDB_DONE_I, .BLANK_I, .VOL_OVFL_I,
        .WRITE_TRY_I, .CHECK_O, .CLR_RESERVE_O);
    tsdb_host_model i_tsdb_host_model (.clk_i(SYS_CLK_I), .slow_i(slow), .cmd_valid_o(CMD_VALID_I),
        .cmd_host_o(CMD_HOST_I), .cmd_sense_o(CMD_SENSE_I), .cmd_alloc_o(CMD_ALLOC_I), .cmd_done_i(CMD_DONE_O),
        .cmd_status_i(CMD_STATUS_O), .cmd_exec_i(CMD_EXEC_O), .sense_valid_i(SENSE_VALID_O),
        .sense_data_i(SENSE_DATA_O), .sense_ready_o(SENSE_READY_I));
    // ****************************************
    // access tasks
    // ****************************************
    task chk(input [31:0] got, input [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task bus(input w, input [2:0] a, input [31:0] d);
        @(posedge SYS_CLK_I);
        AVS_READ_I <= !w;
        AVS_WRITE_I <= w;
        AVS_ADDRESS_I <= a;
        AVS_WRITEDATA_I <= d;
        do
            @(posedge SYS_CLK_I);
        while (AVS_WAITREQUEST_O !== 1'b0);
        q = AVS_READDATA_O;
        r = AVS_RESPONSE_O;
        AVS_READ_I <= 1'b0;
        AVS_WRITE_I <= 1'b0;
    endtask
    task rd(input [2:0] a, input [31:0] m, input [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task pulse(input int b, input int cnt);
        repeat (cnt)
        begin
            @(posedge SYS_CLK_I);
            ev[b] <= 1'b1;
            @(posedge SYS_CLK_I);
            ev[b] <= 1'b0;
        end
    endtask
    task host(input [2:0] h, input s, input [7:0] a, input [2:0] e);
        i_tsdb_host_model.cmd(h, s, a);
        chk(i_tsdb_host_model.res, e);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        repeat (16) @(posedge SYS_CLK_I);
        RST_N_I <= 1'b1;
        rd(`TSDB_OFF_SENSE0, 32'hffffffff, 32'h0006_0070);
        rd(3'h1, 32'hffffffff, 32'h0800_0000);
        rd(3'h2, 32'hffffffff, 32'h0000_0100);
        rd(`TSDB_OFF_SENSE3, 32'hffffffff, 32'h0503_0000);
        rd(`TSDB_OFF_STAT, 32'h0000_ff01, 32'h0000_ff00);
        rd(3'h6, 32'hffffffff, 32'h0);
        chk(r, `TSDB_RESP_SLVERR);
        $display("test 1 done");
        host(3'h0, 1'b0, 8'h00, {1'b0, STAT_CHECK});
        host(3'h1, 1'b0, 8'h00, {1'b0, STAT_BUSY});
        host(3'h0, 1'b1, 8'h00, {1'b0, STAT_GOOD});
        chk(i_tsdb_host_model.n, 4);
        chk({i_tsdb_host_model.rx[3], i_tsdb_host_model.rx[2], i_tsdb_host_model.rx[1], i_tsdb_host_model.rx[0]},
            32'h0006_0070);
        rd(`TSDB_OFF_STAT, 32'h1, 32'h0);
        $display("test 2 done");
        host(3'h0, 1'b0, 8'h00, 3'h4);
        bus(1'b1, `TSDB_OFF_CTRL, 32'h1);
        LAST_TRACK_I <= 1'b1;
        NO_CART_I <= 1'b1;
        AT_BOM_I <= 1'b1;
        RESID_COUNT_I <= 32'h0102_0304;
        pulse(2, 1);
        pulse(3, 1);
        pulse(7, 1);
        pulse(8, 1);
        pulse(9, 3);
        pulse(10, 2);
        pulse(11, 1);
        pulse(4, 15);
        rd(3'h2, 32'h4, 32'h0);
        pulse(4, 1);
        pulse(5, 16);
        CHECK_KEY_I <= 4'h3;
        pulse(12, 1);
        slow <= 1'b1;
        host(3'h0, 1'b1, 8'h10, {1'b0, STAT_GOOD});
        chk(i_tsdb_host_model.n, 16);
        for (i = 0; i < 16; i++)
            chk(i_tsdb_host_model.rx[i], exp3[i]);
        rd(`TSDB_OFF_SENSE0, 32'hff, 32'h70);
        slow <= 1'b0;
        LAST_TRACK_I <= 1'b0;
        NO_CART_I <= 1'b0;
        AT_BOM_I <= 1'b0;
        $display("test 3 done");
        for (i = 0; i < 8; i++)
        begin
            bus(1'b1, `TSDB_OFF_CTRL, 32'h1);
            CHECK_KEY_I <= kkey[i];
            WRPROT_I <= (i == 7);
            pulse(kbit[i], 1);
            pulse(15, 1);
            rd(`TSDB_OFF_SENSE0, 32'h000f_0000, {12'h0, kkey[i], 16'h0});
        end
        rd(3'h2, 32'h10, 32'h10);
        $display("test 4 done");
        bus(1'b1, `TSDB_OFF_CTRL, 32'h1);
        pulse(1, 1);
        host(3'h0, 1'b0, 8'h00, {1'b0, STAT_CHECK});
        bus(1'b1, `TSDB_OFF_CTRL, 32'h1);
        pulse(0, 1);
        rd(3'h2, 32'h100, 32'h100);
        rd(`TSDB_OFF_SENSE0, 32'h000f_0000, 32'h0006_0000);
        $display("test 5 done");
        wrap_up;
    end
    initial
    begin
        repeat (20000) @(posedge SYS_CLK_I);
        mismatches++;
        wrap_up;
    end
endmodule
